// ===== pkg/pio_pkg.sv
// package for the programmable io port block: sizes, layout, reset values, carriers
package pio_pkg;
  localparam int NUM_IO     = 87;  // programmable pins, input-only pin excluded
  localparam int PULL_GROUP = 4;   // pins per pull-up control bit
  localparam int NUM_GROUPS = (NUM_IO + PULL_GROUP - 1) / PULL_GROUP;
  // multiplexed data port position in the flat pin vector
  localparam int MUX_LSB    = 8;
  localparam int MUX_WIDTH  = 8;
  // pull-up groups shared with the external bus: low ports, nibble port, control port
  localparam logic [NUM_GROUPS-1:0] BUS_GROUP_MASK = 22'h000DFF;
  // reset values
  localparam logic [NUM_IO-1:0]     DIR_RESET   = '0;  // all inputs
  localparam logic [NUM_IO-1:0]     LATCH_RESET = '0;
  localparam logic [NUM_GROUPS-1:0] PULL_RESET  = '0;
  localparam logic                  RDSEL_RESET = 1'b0;

  // processor operating mode as seen by the port block
  typedef struct packed {
    logic expansion_mode;  // memory expansion or microprocessor mode
    logic bus_8bit;        // external data bus 8 bits wide
    logic mux_whole_space; // multiplexed bus over whole space, port usable
  } pio_mode_type;

  // pad side drive of the programmable pins
  typedef struct packed {
    logic [NUM_IO-1:0] out;
    logic [NUM_IO-1:0] oe;
    logic [NUM_IO-1:0] pull;
  } pio_pad_type;
endpackage

// ===== logic/pio_pull_ctrl.sv
// pull-up enable per pin from the per-group control bits
`timescale 1ns/1ps
module pio_pull_ctrl #(
  parameter int NUM_IO     = pio_pkg::NUM_IO,
  parameter int NUM_GROUPS = pio_pkg::NUM_GROUPS
) (
  input  wire logic [NUM_GROUPS-1:0] pull_en_i,
  input  wire logic [NUM_GROUPS-1:0] bus_group_i,
  input  wire logic                  expansion_mode_i,
  input  wire logic [NUM_IO-1:0]     drive_i,
  output logic      [NUM_IO-1:0]     pull_o
);
  // group index of a pin
  function automatic int group_of(input int pin);
    return pin / pio_pkg::PULL_GROUP;
  endfunction

  // bus modes mask the shared groups; a driven pin never gets its pull-up
  logic [NUM_GROUPS-1:0] group_live;
  assign group_live = pull_en_i & ~({NUM_GROUPS{expansion_mode_i}} & bus_group_i);

  for (genvar i = 0; i < NUM_IO; i++) begin : g_pin
    assign pull_o[i] = group_live[group_of(i)] & ~drive_i[i];
  end
endmodule

// ===== logic/pio_ports.sv
// programmable io ports: direction, latch, pull-up, read select and pin drive
`timescale 1ns/1ps
module pio_ports #(
  parameter int NUM_IO     = pio_pkg::NUM_IO,
  parameter int NUM_GROUPS = pio_pkg::NUM_GROUPS
) (
  input  wire logic                  clk_i,
  input  wire logic                  srst_i,
  input  wire pio_pkg::pio_mode_type mode_i,
  input  wire logic                  dir_we_i,
  input  wire logic [NUM_IO-1:0]     dir_wdata_i,
  input  wire logic                  latch_we_i,
  input  wire logic [NUM_IO-1:0]     latch_wdata_i,
  input  wire logic                  pull_we_i,
  input  wire logic [NUM_GROUPS-1:0] pull_wdata_i,
  input  wire logic                  rdsel_we_i,
  input  wire logic                  rdsel_wdata_i,
  input  wire logic [NUM_IO-1:0]     periph_oe_i,
  input  wire logic [NUM_IO-1:0]     periph_out_i,
  input  wire logic [NUM_IO-1:0]     pin_in_i,
  input  wire logic                  input_only_pin_i,
  output pio_pkg::pio_pad_type       pad_o,
  output logic      [NUM_IO-1:0]     port_rdata_o,
  output logic                       input_only_rdata_o,
  output logic      [NUM_IO-1:0]     dir_o,
  output logic      [NUM_GROUPS-1:0] pull_en_o,
  output logic                       rdsel_o
);
  logic [NUM_IO-1:0]     dir_q;
  logic [NUM_IO-1:0]     latch_q;
  logic [NUM_GROUPS-1:0] pull_q;
  logic                  rdsel_q;
  logic [NUM_IO-1:0]     rdata_q;
  logic [NUM_IO-1:0]     rdata_d;
  logic                  in_only_q;

  // control registers; a whole vector is written in one strobe
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      dir_q   <= pio_pkg::DIR_RESET;
      latch_q <= pio_pkg::LATCH_RESET;
      pull_q  <= pio_pkg::PULL_RESET;
      rdsel_q <= pio_pkg::RDSEL_RESET;
    end else begin
      if (dir_we_i) begin
        dir_q <= dir_wdata_i;
      end
      if (latch_we_i) begin
        latch_q <= latch_wdata_i;
      end
      if (pull_we_i) begin
        pull_q <= pull_wdata_i;
      end
      if (rdsel_we_i) begin
        rdsel_q <= rdsel_wdata_i;
      end
    end
  end

  // pin drive: peripheral output wins over the direction bit
  wire [NUM_IO-1:0] drive = dir_q | periph_oe_i;
  assign pad_o.oe  = drive;
  assign pad_o.out = (periph_oe_i & periph_out_i) | (~periph_oe_i & latch_q);

  // pull-up gating lives in the leaf so the group mapping stays in one place
  pio_pull_ctrl #(
    .NUM_IO     (NUM_IO),
    .NUM_GROUPS (NUM_GROUPS)
  ) u_pull (
    .pull_en_i        (pull_q),
    .bus_group_i      (pio_pkg::BUS_GROUP_MASK),
    .expansion_mode_i (mode_i.expansion_mode),
    .drive_i          (drive),
    .pull_o           (pad_o.pull)
  );

  // read select only counts in the two listed bus configurations
  wire rdsel_valid = (mode_i.expansion_mode & mode_i.bus_8bit) | mode_i.mux_whole_space;
  wire rdsel_eff   = rdsel_q & rdsel_valid;
  // direction bit, not peripheral override, picks latch versus pin on read
  wire [NUM_IO-1:0] normal_rd = (dir_q & latch_q) | (~dir_q & pin_in_i);
  wire [NUM_IO-1:0] mux_mask  = {{(NUM_IO-pio_pkg::MUX_LSB-pio_pkg::MUX_WIDTH){1'b0}},
                                 {pio_pkg::MUX_WIDTH{1'b1}}, {pio_pkg::MUX_LSB{1'b0}}};
  assign rdata_d = rdsel_eff ? ((mux_mask & latch_q) | (~mux_mask & normal_rd)) : normal_rd;

  // read data registered: one cycle from pin to read port
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_q   <= '0;
      in_only_q <= 1'b0;
    end else begin
      rdata_q   <= rdata_d;
      in_only_q <= input_only_pin_i;
    end
  end

  // input-only pin has no drive, pull or direction path at all
  assign port_rdata_o       = rdata_q;
  assign input_only_rdata_o = in_only_q;
  assign dir_o              = dir_q;
  assign pull_en_o          = pull_q;
  assign rdsel_o            = rdsel_q;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  // first sampled edge after release: an attempt begun inside reset would be disabled
  a_dir_reset_in: assert property ($fell(srst_i) |-> dir_o == '0 && pull_en_o == '0 && !rdsel_o)
    else $error("control state not cleared by reset");
  a_dir_write: assert property (dir_we_i |=> pad_o.oe == ($past(dir_wdata_i) | periph_oe_i))
    else $error("direction write not reflected on pin drive");
  a_periph_wins: assert property (periph_oe_i[0] |-> pad_o.oe[0] && pad_o.out[0] == periph_out_i[0])
    else $error("peripheral output not driving pin");
  a_pull_out_off: assert property (pad_o.oe[20] |-> !pad_o.pull[20])
    else $error("pull-up applied on output pin");
  a_pull_group: assert property (!mode_i.expansion_mode && !pad_o.oe[84] && !pad_o.oe[86]
                                 |-> pad_o.pull[84] == pad_o.pull[86])
    else $error("pins of one group disagree on pull-up");
  a_pull_bus_mode: assert property (mode_i.expansion_mode |-> pad_o.pull[31:0] == '0)
    else $error("pull-up on bus group in bus mode");
  a_read_input: assert property (!dir_o[3] ##1 !$past(dir_q[3]) |-> port_rdata_o[3] == $past(pin_in_i[3]))
    else $error("input pin read does not return pin level");
  a_read_latch: assert property (rdsel_eff |=> port_rdata_o[15:8] == $past(latch_q[15:8]))
    else $error("select 1 does not return latch");
  a_rdsel_gate: assert property (rdsel_q && !rdsel_valid && !dir_q[8] |=> port_rdata_o[8] == $past(pin_in_i[8]))
    else $error("read select acted outside valid bus configuration");
  a_in_only: assert property (1'b1 |=> input_only_rdata_o == $past(input_only_pin_i))
    else $error("input-only pin read wrong");
  // an output pin without peripheral use shows its latch
  a_out_latch: assert property (dir_q[5] && !periph_oe_i[5] |-> pad_o.oe[5] && pad_o.out[5] == latch_q[5])
    else $error("output pin does not show latch");
  // no direction bit and no peripheral: the pin is released
  a_idle_release: assert property (!dir_q[7] && !periph_oe_i[7] |-> !pad_o.oe[7])
    else $error("input pin still driven");
  // enabled group outside bus mode pulls its undriven pins
  a_pull_live: assert property (!mode_i.expansion_mode && pull_q[10] && !pad_o.oe[40] |-> pad_o.pull[40])
    else $error("enabled pull-up missing on input pin");

  c_periph_drive: cover property (periph_oe_i[0] && !dir_q[0]);
  c_latch_read:   cover property (rdsel_eff ##1 rdsel_eff);
  c_pull_active:  cover property (pad_o.pull[40] && !mode_i.expansion_mode);
  c_bus8_select:  cover property (mode_i.expansion_mode && mode_i.bus_8bit && rdsel_q);
endmodule

// ===== sim/pio_pin_model.sv
// board model around the port pins: drivers, pull-ups, external sources
`timescale 1ns/1ps
module pio_pin_model (
  input  wire pio_pkg::pio_pad_type pad_i,
  input  wire logic [86:0]          ext_i,
  input  wire logic [86:0]          ext_en_i,
  output logic      [86:0]          pin_o
);
  // an external source only drives pins that the port leaves as input
  // a released unpulled line floats away from the last drive, not to a fixed 0
  assign pin_o = (pad_i.oe & pad_i.out) | (~pad_i.oe & ext_en_i & ext_i)
               | (~pad_i.oe & ~ext_en_i & (pad_i.pull | ~pad_i.out));
endmodule

// ===== sim/tb_top.sv
// self-checking bench for the programmable io ports
`timescale 1ns/1ps
module tb_top;
  localparam logic [86:0] P1 = 87'h5A5A_5A5A_5A5A_5A5A_5A5A_5A;
  localparam logic [86:0] P2 = 87'h3C3C_3C3C_3C3C_3C3C_3C3C_3C;
  localparam logic [86:0] E  = 87'h0F0F_0F0F_0F0F_0F0F_0F0F_0F;
  localparam logic [21:0] PG = 22'h155555;
  logic clk_i = 1'b0, srst_i = 1'b1, dir_we_i = 1'b0, latch_we_i = 1'b0, pull_we_i = 1'b0;
  logic rdsel_we_i = 1'b0, rdsel_wdata_i = 1'b0, input_only_pin_i = 1'b0, input_only_rdata_o, rdsel_o;
  logic [86:0] dir_wdata_i = '0, latch_wdata_i = '0, periph_oe_i = '0, periph_out_i = '0, ext_en = '1;
  logic [86:0] pin_in_i, port_rdata_o, dir_o, x;
  logic [21:0] pull_wdata_i = '0, pull_en_o;
  pio_pkg::pio_mode_type mode_i = '0;
  pio_pkg::pio_pad_type  pad_o;
  int miscompares = 0, num_checks = 0;
  always #5 clk_i = ~clk_i;
  pio_ports uut (.clk_i, .srst_i, .mode_i, .dir_we_i, .dir_wdata_i, .latch_we_i, .latch_wdata_i,
    .pull_we_i, .pull_wdata_i, .rdsel_we_i, .rdsel_wdata_i, .periph_oe_i, .periph_out_i, .pin_in_i,
    .input_only_pin_i, .pad_o, .port_rdata_o, .input_only_rdata_o, .dir_o, .pull_en_o, .rdsel_o);
  pio_pin_model board (.pad_i(pad_o), .ext_i(E), .ext_en_i(ext_en), .pin_o(pin_in_i));
  // compare with case inequality so an unknown never matches
  task automatic chk(input string nm, input logic [86:0] e, input logic [86:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // write all four registers at once, then let the read path settle
  task automatic put(input logic [86:0] d, input logic [86:0] l, input logic [21:0] p, input logic r);
    @(negedge clk_i);
    {dir_we_i, latch_we_i, pull_we_i, rdsel_we_i} = 4'hF;
    dir_wdata_i = d;
    latch_wdata_i = l;
    pull_wdata_i = p;
    rdsel_wdata_i = r;
    @(negedge clk_i);
    {dir_we_i, latch_we_i, pull_we_i, rdsel_we_i} = 4'h0;
    @(negedge clk_i);
  endtask
  function automatic logic [86:0] grp(input logic [21:0] g);
    for (int i = 0; i < 87; i++) grp[i] = g[i/4];
  endfunction
  task automatic t_reset;
    chk("dir", '0, dir_o);
    chk("pull_en", '0, {65'h0, pull_en_o});
    chk("rdsel", '0, {86'h0, rdsel_o});
    chk("oe", '0, pad_o.oe);
  endtask
  task automatic t_dir;
    input_only_pin_i = 1'b1;
    put(P1, P2, '0, 1'b0);
    chk("dir", P1, dir_o);
    chk("oe", P1, pad_o.oe);
    chk("out", P1 & P2, P1 & pad_o.out);
    chk("rdata", (P1 & P2) | (~P1 & E), port_rdata_o);
    chk("only", 87'h1, {86'h0, input_only_rdata_o});
  endtask
  task automatic t_pull;
    put(P1, P2, PG, 1'b0);
    chk("pull_en", {65'h0, PG}, {65'h0, pull_en_o});
    chk("pull", ~P1 & grp(PG), pad_o.pull);
    // external sources off: pulled inputs read high, unpulled ones float
    ext_en = '0;
    @(negedge clk_i);
    chk("rd_pull", (P1 & P2) | (~P1 & (grp(PG) | ~P2)), port_rdata_o);
    ext_en = '1;
    mode_i.expansion_mode = 1'b1;
    put(P1, P2, PG, 1'b0);
    chk("pull_bus", ~P1 & grp(PG & ~pio_pkg::BUS_GROUP_MASK), pad_o.pull);
    mode_i = '0;
  endtask
  task automatic t_periph;
    periph_oe_i = E;
    periph_out_i = P2;
    put(P1, '0, '1, 1'b0);
    chk("oe_per", P1 | E, pad_o.oe);
    chk("out_per", P2 & E, E & pad_o.out);
    chk("pull_per", ~(P1 | E), pad_o.pull);
    periph_oe_i = '0;
  endtask
  task automatic t_rdsel;
    x = E;
    x[15:8] = P2[15:8];
    mode_i.mux_whole_space = 1'b1;
    put('0, P2, '0, 1'b1);
    chk("rd_latch", x, port_rdata_o);
    mode_i = '0;
    mode_i.bus_8bit = 1'b1;
    put('0, P2, '0, 1'b1);
    chk("rd_ignored", E, port_rdata_o);
    mode_i.expansion_mode = 1'b1;
    input_only_pin_i = 1'b0;
    @(negedge clk_i);
    chk("rd_latch8", x, port_rdata_o);
    chk("only0", '0, {86'h0, input_only_rdata_o});
    mode_i = '0;
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge clk_i);
    srst_i = 1'b0;
    t_reset;
    t_dir;
    t_pull;
    t_periph;
    t_rdsel;
    stop_test;
  end
  // the tests need under 40 cycles, so a hang is cut well before the run grows long
  initial begin
    #5000;
    miscompares++;
    stop_test;
  end
endmodule
